// *** common/urmc_pkg.sv ***
// Package: shared constants and types of the RS-485 / multidrop line control.
// Assumes writable registers sit in byte lane 0 of 32-bit AXI4-Lite words.
package urmc_pkg;
   // Register indices; byte address is four times the index
   localparam int ADDR_W = 8;
   localparam logic [5:0] IDX_FLOW = 6'h0c;
   localparam logic [5:0] IDX_UNICAST = 6'h10;
   localparam logic [5:0] IDX_MULTICAST = 6'h11;
   localparam logic [5:0] IDX_TURNAROUND = 6'h15;
   localparam logic [5:0] IDX_PINSEL = 6'h1a;
   localparam logic [5:0] IDX_STATUS = 6'h20;
   // Field positions
   localparam int FLOW_HDX_BIT = 3;
   localparam int PINSEL_POL_BIT = 3;
   localparam int ST_MATCH_BIT = 0;
   localparam int ST_DIR_BIT = 1;
   localparam int ST_TXEN_BIT = 2;
   localparam int ST_RXEN_BIT = 3;
   localparam int ST_LEVEL_LSB = 4;
   // Reset values
   localparam logic [7:0] FLOW_RST = 8'h00;
   localparam logic [7:0] UNICAST_RST = 8'h00;
   localparam logic [7:0] MULTICAST_RST = 8'h00;
   localparam logic [3:0] TURNAROUND_RST = 4'h0;
   localparam logic [7:0] PINSEL_RST = 8'h00;
   // Pin-function code that selects direction control
   localparam logic [2:0] PINSEL_RS485 = 3'h3;
   // Bus responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [2:0] {
      FLOW_NONE = 3'b000,
      FLOW_HW = 3'b001,
      FLOW_INBAND = 3'b010,
      FLOW_ADDR_TXON = 3'b011,
      FLOW_ADDR_TXGATE = 3'b100
   } urmc_flow_t;

   typedef enum logic [1:0] {
      DIR_IDLE = 2'b00,
      DIR_LEAD = 2'b01,
      DIR_SEND = 2'b10,
      DIR_HOLD = 2'b11
   } urmc_dir_t;
endpackage

// *** design/urmc_fifo.sv ***
// Flip-flop FIFO with valid/ready on both sides.
// Assumes one clock; DEPTH of at least two.
`timescale 1ns/100ps
module urmc_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rstn,
   // Fill side
   input wire logic inValid,
   input wire logic [WIDTH-1:0] inData,
   output logic inReady,
   // Drain side
   output logic outValid,
   output logic [WIDTH-1:0] outData,
   input wire logic outReady,
   // Fill level
   output logic [$clog2(DEPTH):0] level
);
   localparam int PW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [PW-1:0] wrPtr;
   logic [PW-1:0] rdPtr;
   logic push;
   logic pop;

   assign inReady = (level != (PW+1)'(DEPTH));
   assign outValid = (level != '0);
   assign push = inValid && inReady;
   assign pop = outValid && outReady;
   assign outData = mem[rdPtr];

   always_ff @(posedge clk_sys) begin
      if (push) begin
         mem[wrPtr] <= inData;
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         wrPtr <= '0;
         rdPtr <= '0;
         level <= '0;
      end else begin
         if (push) begin
            wrPtr <= (wrPtr == PW'(DEPTH - 1)) ? '0 : wrPtr + 1'b1;
         end
         if (pop) begin
            rdPtr <= (rdPtr == PW'(DEPTH - 1)) ? '0 : rdPtr + 1'b1;
         end
         if (push && !pop) begin
            level <= level + 1'b1;
         end else if (pop && !push) begin
            level <= level - 1'b1;
         end
      end
   end
endmodule // urmc_fifo

// *** design/urmc_line_ctl.sv ***
// Line control of one UART channel: RS-485 direction, multidrop match,
// half-duplex receive gating, receive FIFO, AXI4-Lite registers.
// Assumes txActive covers start to last stop bit and bitTick pulses once per bit.
// Behaviour
// - Direction output goes active before the transmitter starts its first bit.
// - With no delay, direction releases right after the last stop bit.
// - Pin-select bit 3 sets the active level of the direction output.
// - Release is postponed by 1 to 15 bit periods from the delay register.
// - Flow modes 3 and 4 select the two address-matching receive modes.
// - Unicast register holds own address, multicast register a shared group address.
// - Ninth bit one marks an address; match on unicast or multicast equality.
// - Matching address is dropped; following data characters enter the receive FIFO.
// - A non-matching address disables the receiver.
// - Flow mode 3 keeps the transmitter always enabled.
// - Flow mode 4 enables the transmitter only while an address match holds.
// - Flow bit 3 ignores receive input while the transmitter is sending.
// - Flow mode 001 is hardware handshake, 010 in-band character flow control.
//
// Design decisions made here: register access over AXI4-Lite and the register addresses.
`timescale 1ns/100ps
module urmc_line_ctl
   import urmc_pkg::*;
#(
   parameter int FIFO_DEPTH = 16,
   parameter int DATA_W = 8
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rstn,
   // AXI4-Lite write
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Transmit shift path
   input wire logic txPending,
   input wire logic txActive,
   input wire logic bitTick,
   output logic txStartGrant,
   output logic txEnable,
   // Receive shift path
   input wire logic rxCharValid,
   input wire logic [DATA_W-1:0] rxChar,
   input wire logic rxNinth,
   output logic rxCharReady,
   // Receive FIFO drain
   output logic rxOutValid,
   output logic [DATA_W-1:0] rxOutData,
   input wire logic rxOutReady,
   // Line and flow control
   output logic directionCtlPin,
   output logic rxEnable,
   output logic hwFlowEn,
   output logic swFlowEn
);
   localparam int LW = $clog2(FIFO_DEPTH) + 1;

   logic [7:0] flowCtl;
   logic [7:0] unicastAddr;
   logic [7:0] multicastAddr;
   logic [3:0] turnaroundDelay;
   logic [7:0] pinSel;
   urmc_flow_t flowMode;
   urmc_dir_t dirState;
   urmc_dir_t next_dirState;
   logic [3:0] holdCnt;
   logic matched;
   logic rs485On;
   logic polHigh;
   logic dirActive;
   logic addrMode;
   logic isAddr;
   logic addrHit;
   logic hdxBlock;
   logic rxDrop;
   logic fifoPush;
   logic fifoInReady;
   logic [LW-1:0] fifoLevel;
   logic wrGo;
   logic rdGo;
   logic [5:0] wrIdx;
   logic [5:0] rdIdx;
   logic [31:0] rdValue;
   logic rdHit;
   logic wrHit;

   // Register bus
   assign wrIdx = s_axi_awaddr[ADDR_W-1:2];
   assign rdIdx = s_axi_araddr[ADDR_W-1:2];
   assign wrGo = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
   assign s_axi_awready = wrGo;
   assign s_axi_wready = wrGo;
   assign rdGo = s_axi_arvalid && !s_axi_rvalid;
   assign s_axi_arready = !s_axi_rvalid;

   always_comb begin
      case (wrIdx)
         IDX_FLOW, IDX_UNICAST, IDX_MULTICAST, IDX_TURNAROUND, IDX_PINSEL: wrHit = 1'b1;
         default: wrHit = 1'b0;
      endcase
   end

   always_comb begin
      rdHit = 1'b1;
      rdValue = '0;
      case (rdIdx)
         IDX_FLOW: rdValue[7:0] = flowCtl;
         IDX_UNICAST: rdValue[7:0] = unicastAddr;
         IDX_MULTICAST: rdValue[7:0] = multicastAddr;
         IDX_TURNAROUND: rdValue[3:0] = turnaroundDelay;
         IDX_PINSEL: rdValue[7:0] = pinSel;
         IDX_STATUS: begin
            rdValue[ST_MATCH_BIT] = matched;
            rdValue[ST_DIR_BIT] = dirActive;
            rdValue[ST_TXEN_BIT] = txEnable;
            rdValue[ST_RXEN_BIT] = rxEnable;
            rdValue[ST_LEVEL_LSB +: LW] = fifoLevel;
         end
         default: rdHit = 1'b0;
      endcase
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         flowCtl <= FLOW_RST;
         unicastAddr <= UNICAST_RST;
         multicastAddr <= MULTICAST_RST;
         turnaroundDelay <= TURNAROUND_RST;
         pinSel <= PINSEL_RST;
      end else if (wrGo && s_axi_wstrb[0]) begin
         case (wrIdx)
            IDX_FLOW: flowCtl <= {4'h0, s_axi_wdata[3:0]};
            IDX_UNICAST: unicastAddr <= s_axi_wdata[7:0];
            IDX_MULTICAST: multicastAddr <= s_axi_wdata[7:0];
            IDX_TURNAROUND: turnaroundDelay <= s_axi_wdata[3:0];
            IDX_PINSEL: pinSel <= {4'h0, s_axi_wdata[3:0]};
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else if (wrGo) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wrHit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= RESP_OKAY;
      end else if (rdGo) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rdValue;
         s_axi_rresp <= rdHit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // Mode decode
   assign flowMode = urmc_flow_t'(flowCtl[2:0]);
   assign addrMode = (flowMode == FLOW_ADDR_TXON) || (flowMode == FLOW_ADDR_TXGATE);
   assign hwFlowEn = (flowMode == FLOW_HW);
   assign swFlowEn = (flowMode == FLOW_INBAND);
   assign rs485On = (pinSel[2:0] == PINSEL_RS485);
   assign polHigh = pinSel[PINSEL_POL_BIT];
   assign txEnable = (flowMode != FLOW_ADDR_TXGATE) || matched;

   // Direction control sequence
   always_comb begin
      next_dirState = dirState;
      case (dirState)
         DIR_IDLE: begin
            if (rs485On && txPending && txEnable) begin
               next_dirState = DIR_LEAD;
            end
         end
         DIR_LEAD: next_dirState = DIR_SEND;
         DIR_SEND: begin
            if (!txActive && !txPending) begin
               next_dirState = (turnaroundDelay == 4'h0) ? DIR_IDLE : DIR_HOLD;
            end
         end
         DIR_HOLD: begin
            if (!rs485On) begin
               next_dirState = DIR_IDLE;
            end else if (txPending && txEnable) begin
               next_dirState = DIR_SEND;
            end else if (bitTick && holdCnt == turnaroundDelay - 4'h1) begin
               next_dirState = DIR_IDLE;
            end
         end
         default: next_dirState = DIR_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         dirState <= DIR_IDLE;
      end else begin
         dirState <= next_dirState;
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         holdCnt <= 4'h0;
      end else if (dirState != DIR_HOLD) begin
         holdCnt <= 4'h0;
      end else if (bitTick) begin
         holdCnt <= holdCnt + 4'h1;
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         directionCtlPin <= 1'b1;
      end else begin
         directionCtlPin <= (next_dirState != DIR_IDLE) ~^ polHigh;
      end
   end

   assign dirActive = (dirState != DIR_IDLE);
   assign txStartGrant = rs485On ? (dirState == DIR_SEND && txEnable) : txEnable;

   // Receive filtering
   assign hdxBlock = flowCtl[FLOW_HDX_BIT] && txActive;
   assign isAddr = addrMode && rxNinth;
   assign addrHit = (rxChar == unicastAddr) || (rxChar == multicastAddr);
   assign rxEnable = !addrMode || matched;
   assign rxDrop = hdxBlock || isAddr || !rxEnable;
   assign rxCharReady = fifoInReady || rxDrop;
   assign fifoPush = rxCharValid && !rxDrop;

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         matched <= 1'b0;
      end else if (rxCharValid && !hdxBlock && isAddr) begin
         matched <= addrHit;
      end
   end

   urmc_fifo #(
      .WIDTH(DATA_W),
      .DEPTH(FIFO_DEPTH)
   ) u_rxFifo (
      .clk_sys(clk_sys),
      .rstn(rstn),
      .inValid(fifoPush),
      .inData(rxChar),
      .inReady(fifoInReady),
      .outValid(rxOutValid),
      .outData(rxOutData),
      .outReady(rxOutReady),
      .level(fifoLevel)
   );

   // Checks
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rstn);

   sequence s_send_done;
      dirState == DIR_SEND && !txActive && !txPending;
   endsequence

   sequence s_hold_last;
      dirState == DIR_HOLD && rs485On && !txPending && bitTick
         && holdCnt == turnaroundDelay - 4'h1;
   endsequence

   sequence s_addr_in(logic hit);
      rxCharValid && !hdxBlock && isAddr && addrHit == hit;
   endsequence

   a_dir_before_start: assert property (
      (rs485On && txStartGrant) |-> dirActive && $past(dirActive))
      else $error("start granted before direction was active");

   a_dir_release_now: assert property (
      (s_send_done and turnaroundDelay == 4'h0) |=> dirState == DIR_IDLE)
      else $error("direction not released after last stop bit");

   a_pin_level: assert property (
      ($stable(pinSel) && rs485On) |-> directionCtlPin == (dirActive ~^ polHigh))
      else $error("direction pin level wrong for polarity");

   a_hold_end: assert property (s_hold_last |=> dirState == DIR_IDLE)
      else $error("direction held past programmed delay");

   a_hold_keep: assert property (
      (dirState == DIR_HOLD && rs485On && !txPending && bitTick
         && holdCnt != turnaroundDelay - 4'h1) |=> dirState == DIR_HOLD)
      else $error("direction released early");

   a_hold_enter: assert property (
      (s_send_done and turnaroundDelay != 4'h0) |=> dirState == DIR_HOLD && holdCnt == 4'h0)
      else $error("turn-around hold not started");

   a_addr_dropped: assert property ((rxCharValid && isAddr) |-> !fifoPush)
      else $error("address character entered the FIFO");

   a_data_kept: assert property (
      (rxCharValid && addrMode && !rxNinth && matched && !hdxBlock && fifoInReady)
         |-> fifoPush && rxCharReady)
      else $error("matched data character lost");

   a_miss_disables: assert property (s_addr_in(1'b0) |=> !rxEnable && !matched)
      else $error("receiver left enabled after address miss");

   a_hit_enables: assert property (s_addr_in(1'b1) |=> matched && rxEnable)
      else $error("receiver not enabled after address match");

   a_mode3_tx: assert property (
      (flowMode == FLOW_ADDR_TXON) |-> txEnable && (rs485On || txStartGrant))
      else $error("transmitter disabled in mode 3");

   a_mode4_tx: assert property (
      (s_addr_in(1'b0) ##1 (flowMode == FLOW_ADDR_TXGATE)) |-> !txEnable && !txStartGrant)
      else $error("transmitter enabled without match in mode 4");

   a_hdx_ignore: assert property (
      (flowCtl[FLOW_HDX_BIT] && txActive && rxCharValid) |-> !fifoPush ##1 $stable(matched))
      else $error("receive data taken while transmitting half-duplex");

   a_flow_decode: assert property (
      ($past(flowCtl[2:0]) == 3'h1 && $stable(flowCtl)) |-> hwFlowEn && !swFlowEn)
      else $error("hardware handshake mode not decoded");
endmodule // urmc_line_ctl

// *** tb/urmc_tb.sv ***
// Bench: line control against a queue model of its line and receive rules.
// Assumes the transmit channel model stands on the shift path side.
`timescale 1ns/100ps
module tb;
   import urmc_pkg::*;
   logic clk_sys = 1'b0, rstn = 1'b0;
   logic awValid = 1'b0, wValid = 1'b0, bReady = 1'b0, arValid = 1'b0, rReady = 1'b0;
   logic rxCharValid = 1'b0, rxNinth = 1'b0, rxOutReady = 1'b0, sendReq = 1'b0;
   logic [7:0] awAddr = 8'h00, arAddr = 8'h00, rxChar = 8'h00, v, oD, rxOutData;
   logic [31:0] wData = 32'h0, rData, rD;
   logic [3:0] sendCount = 4'h0;
   logic [1:0] bResp, rResp, bR, rR;
   logic awReady, wReady, bValid, arReady, rValid, txPending, txActive, bitTick, act, pS;
   logic txStartGrant, txEnable, rxCharReady, rxOutValid, directionCtlPin, rxEnable;
   logic hwFlowEn, swFlowEn;
   int badCount = 0, cmpCount = 0, seed = 80, mode = 0, hdx = 0, matched = 0, t, g, i;
   int q[$];
   int dl[3] = '{0, 1, 15};
   logic [5:0] ri[5] = '{IDX_FLOW, IDX_UNICAST, IDX_MULTICAST, IDX_TURNAROUND, IDX_PINSEL};
   logic [7:0] rv[5] = '{FLOW_RST, UNICAST_RST, MULTICAST_RST, 8'(TURNAROUND_RST), PINSEL_RST};
   logic [7:0] wm[5] = '{8'h0b, 8'hff, 8'hff, 8'hff, 8'h0f};
   logic [7:0] rm[5] = '{8'h0f, 8'hff, 8'hff, 8'h0f, 8'h0f};
   logic [7:0] ac[9] = '{8'h21, 8'h5a, 8'h01, 8'hfe, 8'h5a, 8'h11, 8'h33, 8'hc3, 8'h44};
   logic [8:0] an = 9'h0a2;
   always #2 clk_sys = ~clk_sys;
   urmc_line_ctl #(.FIFO_DEPTH(16), .DATA_W(8)) uut (.clk_sys, .rstn,
      .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
      .s_axi_wdata(wData), .s_axi_wstrb(4'h1), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
      .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
      .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
      .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
      .txPending, .txActive, .bitTick, .txStartGrant, .txEnable, .rxCharValid, .rxChar,
      .rxNinth, .rxCharReady, .rxOutValid, .rxOutData, .rxOutReady, .directionCtlPin,
      .rxEnable, .hwFlowEn, .swFlowEn);
   urmc_tx_model txm (.clk_sys, .rstn, .sendReq, .sendCount, .txStartGrant, .txPending,
      .txActive, .bitTick);
   function automatic logic sig(input int k);
      case (k)
         0: return awReady && wReady;
         1: return bValid;
         2: return arReady;
         3: return rValid;
         4: return rxCharReady;
         5: return txActive;
         6: return !txActive && !txPending;
         default: return rxOutValid;
      endcase
   endfunction
   task completeRun();
      $display("compares %0d mismatches %0d", cmpCount, badCount);
      if (badCount == 0 && cmpCount > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // Wait for a handshake, keeping what the answer carries at that edge
   task automatic waitOn(input int k);
      logic a;
      for (int n = 0; n < 400; n++) begin
         #1;
         a = sig(k);
         bR = bResp;
         rD = rData;
         rR = rResp;
         act = txActive;
         pS = directionCtlPin;
         oD = rxOutData;
         @(posedge clk_sys);
         if (a === 1'b1) return;
      end
      $display("timeout at %0t", $time);
      badCount++;
      completeRun();
   endtask
   task chk(input logic [31:0] s, input logic [31:0] e);
      cmpCount++;
      if (s !== e) begin
         badCount++;
         $display("mismatch at %0t seen %h expected %h", $time, s, e);
      end
   endtask
   task axw(input logic [5:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      awAddr <= {a, 2'h0};
      wData <= {24'h0, d};
      awValid <= 1'b1;
      wValid <= 1'b1;
      bReady <= 1'b1;
      waitOn(0);
      awValid <= 1'b0;
      wValid <= 1'b0;
      waitOn(1);
      bReady <= 1'b0;
   endtask
   task axr(input logic [5:0] a);
      @(posedge clk_sys);
      arAddr <= {a, 2'h0};
      arValid <= 1'b1;
      rReady <= 1'b1;
      waitOn(2);
      arValid <= 1'b0;
      waitOn(3);
      rReady <= 1'b0;
   endtask
   task setFlow(input int m, input int h);
      axw(IDX_FLOW, 8'(m + 8 * h));
      chk(bR, RESP_OKAY);
      mode = m;
      hdx = h;
      #1;
   endtask
   task txGo(input logic [3:0] n);
      @(posedge clk_sys);
      sendCount <= n;
      sendReq <= 1'b1;
      @(posedge clk_sys);
      sendReq <= 1'b0;
   endtask
   // Count bit ticks from the last stop bit to the release of direction
   task txEnd(input int d, input logic p);
      waitOn(6);
      t = 0;
      for (g = 0; g < 200; g++) begin
         #1;
         if (directionCtlPin !== p) break;
         if (bitTick === 1'b1) t++;
         @(posedge clk_sys);
      end
      chk(t, d);
      if (d == 0) chk(g, 0);
   endtask
   task rx(input logic [7:0] c, input logic n);
      @(posedge clk_sys);
      rxCharValid <= 1'b1;
      rxChar <= c;
      rxNinth <= n;
      waitOn(4);
      rxCharValid <= 1'b0;
      if (hdx == 0 || act === 1'b0) begin
         if (mode >= 3 && n) matched = (c == ac[1] || c == ac[7]);
         else if (mode < 3 || matched != 0) q.push_back(c);
      end
   endtask
   task drain(input int n);
      @(posedge clk_sys);
      rxOutReady <= 1'b1;
      repeat (n) begin
         waitOn(7);
         chk(oD, q.pop_front());
      end
      rxOutReady <= 1'b0;
      #1;
      chk(rxOutValid, 1'b0);
   endtask
   initial begin
      repeat (6) @(posedge clk_sys);
      rstn <= 1'b1;
      axr(IDX_STATUS);
      chk(rD, 32'h0c);
      #1;
      chk(directionCtlPin, 1'b1);
      axr(6'h01);
      chk(rR, RESP_SLVERR);
      chk(rD, 32'h0);
      axw(IDX_STATUS, 8'hff);
      chk(bR, RESP_SLVERR);
      for (i = 0; i < 5; i++) begin
         axr(ri[i]);
         chk(rD, rv[i]);
         v = 8'($random(seed)) & wm[i];
         axw(ri[i], v);
         chk(bR, RESP_OKAY);
         axr(ri[i]);
         chk(rD, v & rm[i]);
      end
      $display("test registers done");
      for (i = 0; i < 5; i++) begin
         setFlow(i, 0);
         chk(hwFlowEn, i == 1);
         chk(swFlowEn, i == 2);
         chk(txEnable, i != 4);
         chk(rxEnable, i < 3);
      end
      $display("test flow modes done");
      setFlow(0, 0);
      for (i = 0; i < 3; i++) begin
         axw(IDX_PINSEL, {4'h0, i[0], 3'h3});
         axw(IDX_TURNAROUND, 8'(dl[i]));
         #1;
         chk(directionCtlPin, !i[0]);
         txGo(4'(i + 1));
         waitOn(5);
         chk(pS, i[0]);
         txEnd(dl[i], i[0]);
      end
      $display("test direction done");
      axw(IDX_UNICAST, ac[1]);
      axw(IDX_MULTICAST, ac[7]);
      setFlow(3, 0);
      for (i = 0; i < 9; i++) begin
         rx(ac[i], an[i]);
         #1;
         chk(rxEnable, matched);
         chk(txEnable, 1'b1);
      end
      drain(q.size());
      setFlow(4, 0);
      rx(8'h11, 1'b1);
      #1;
      chk(txEnable, 1'b0);
      txGo(4'h1);
      repeat (8) @(posedge clk_sys);
      #1;
      chk(txStartGrant, 1'b0);
      chk(directionCtlPin, 1'b1);
      rx(ac[7], 1'b1);
      #1;
      chk(txEnable, 1'b1);
      waitOn(5);
      chk(pS, 1'b0);
      txEnd(15, 1'b0);
      $display("test multidrop done");
      setFlow(0, 1);
      axw(IDX_TURNAROUND, 8'h00);
      txGo(4'h1);
      waitOn(5);
      rx(8'h77, 1'b0);
      axr(IDX_STATUS);
      chk(rD[8:4], q.size());
      txEnd(0, 1'b0);
      rx(8'h78, 1'b0);
      drain(q.size());
      $display("test half duplex done");
      setFlow(0, 0);
      for (i = 0; i < 16; i++) rx(8'($random(seed)), 1'b0);
      fork
         rx(8'h5e, 1'b0);
      join_none
      repeat (4) @(posedge clk_sys);
      #1;
      chk(rxCharReady, 1'b0);
      axr(IDX_STATUS);
      chk(rD, 32'h10c | matched);
      drain(17);
      $display("test fifo done");
      completeRun();
   end
endmodule // tb

// *** tb/urmc_tx_model.sv ***
// Transmit channel model: queued characters and free-running bit ticks.
// Assumes the line control grants each start; ten bits per character.
`timescale 1ns/100ps
module urmc_tx_model (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rstn,
   // Bench control
   input wire logic sendReq,
   input wire logic [3:0] sendCount,
   // Shift path side
   input wire logic txStartGrant,
   output logic txPending,
   output logic txActive,
   output logic bitTick
);
   logic [3:0] remain, bitCount;
   logic [1:0] div;
   assign txPending = (remain != 4'h0);
   assign bitTick = (div == 2'h3);
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         div <= 2'h0;
         remain <= 4'h0;
         txActive <= 1'b0;
         bitCount <= 4'h0;
      end else begin
         div <= div + 2'h1;
         if (sendReq) begin
            remain <= sendCount;
         end else if (!txActive && txPending && txStartGrant) begin
            // Never start before the grant
            txActive <= 1'b1;
            remain <= remain - 4'h1;
            bitCount <= 4'h0;
         end else if (txActive && bitTick) begin
            bitCount <= bitCount + 4'h1;
            txActive <= (bitCount != 4'h9);
         end
      end
   end
endmodule // urmc_tx_model
